//--- logic/pmc_regs_cfg.svh
// Purpose: constants for the charger setup and interrupt acknowledge register bank
// Assumes: 8-bit registers reached over the two-wire serial port
// Notes: device address, offsets, bit positions, reset values, unmapped read value and bit counts only
//
// How it works
// - Set regulator mask bit hides condition; reset FFh
// - Acknowledged charger condition no longer drives interrupt
// - Acknowledged regulator condition no longer drives interrupt
// - Interrupt releases high only when nothing pending
// - Charger acknowledge bit clears when condition leaves
// - Regulator acknowledge bit clears when condition leaves
// - Inhibit clear: valid source without undervolt lockout forces on, standby off
// - Inhibit set: source keeps standby, no auto-on
// - Charger reset bit one-then-zero restarts charging
// - Timer enable selects taper timer or comparator
// - Two-bit field scales constant current 25-100%
// - USB limit 100/500 mA, ignored if USB barred
// - USB-allowed bit zero blocks USB charging
// - Charge enable gates all; wall adapter wins
// - Charger setup at 07h, resets to 1Bh
// - Unmasked regulator flag rise pulls interrupt low
// - Unmasked charger flag drives interrupt active
`ifndef PMC_REGS_CFG_SVH
`define PMC_REGS_CFG_SVH

`define PMC_DEV_ADDR_MSBS 6'b100100
`define PMC_OFS_CHARGE_FLAGS 8'h01
`define PMC_OFS_RAIL_FLAGS 8'h02
`define PMC_OFS_CHARGE_MASK 8'h03
`define PMC_OFS_RAIL_MASK 8'h04
`define PMC_OFS_CHARGE_ACK 8'h05
`define PMC_OFS_RAIL_ACK 8'h06
`define PMC_OFS_CHARGER_SETUP 8'h07
`define PMC_RST_RAIL_MASK 8'hff
`define PMC_RST_ACK 8'h00
`define PMC_RST_CHARGER_SETUP 8'h1b
`define PMC_UNMAPPED_DATA 8'hff
`define PMC_BIT_AUTO_ON_INHIBIT 7
`define PMC_BIT_CHARGER_RESET 6
`define PMC_BIT_TIMER_ENABLE 5
`define PMC_BIT_CURRENT_MSB 4
`define PMC_BIT_CURRENT_LSB 3
`define PMC_BIT_USB_500MA 2
`define PMC_BIT_USB_ALLOWED 1
`define PMC_BIT_CHARGE_ENABLE 0
`define PMC_BITS_PER_BYTE 4'h8
`define PMC_LAST_READ_BIT 4'h7

`endif

//--- logic/pmc_pkg.sv
// Purpose: types shared by the register bank
// Assumes: nothing beyond the constants header
// Notes: serial port state encoding
`default_nettype none
package pmc_pkg;
    typedef enum logic [3:0] {
        PMC_IDLE = 4'h0,
        PMC_ADDR = 4'h1,
        PMC_ADDR_ACK = 4'h2,
        PMC_PTR = 4'h3,
        PMC_PTR_ACK = 4'h4,
        PMC_WDATA = 4'h5,
        PMC_WDATA_ACK = 4'h6,
        PMC_RDATA = 4'h7,
        PMC_RDATA_ACK = 4'h8
    } pmc_state_t;
endpackage
`default_nettype wire

//--- logic/pmc_sync.sv
// Purpose: two-flop synchroniser for a vector of pin levels
// Assumes: bits are independent levels
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module pmc_sync #(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage1;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= '0;
            dout <= '0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule
`default_nettype wire

//--- logic/pmc_charger_irq_regs.sv
// Purpose: regulator mask, acknowledge registers, charger setup and interrupt pin
// Assumes: host on the two-wire serial port; status flags arrive as pin levels
// Notes: open-drain data pin as in/out/enable, enable low while pulling low
`timescale 1ns/10ps
`default_nettype none
`include "pmc_regs_cfg.svh"
module pmc_charger_irq_regs
    import pmc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_b,
    input wire logic addr_lsb,
    input wire logic [7:0] charge_state_flags,
    input wire logic [7:0] rail_state_flags,
    input wire logic [7:0] charge_event_mask,
    input wire logic usb_source_valid,
    input wire logic ac_source_valid,
    input wire logic undervolt_lockout,
    input wire logic taper_comparator,
    input wire logic taper_timer_done,
    output logic irq_b,
    output logic force_on,
    output logic standby_allowed,
    output logic charger_restart,
    output logic fast_timer_enable,
    output logic taper_flag,
    output logic [1:0] charge_current_code,
    output logic usb_limit_500ma,
    output logic usb_charge_on,
    output logic ac_charge_on
);
    logic [23:0] pins_s;
    logic scl_s, sda_s, addr_lsb_s, usb_ok, ac_ok, lockout, taper_cmp, taper_tmr;
    logic [7:0] chg_flags, rail_flags;

    logic scl_inv_s, sda_inv_s;

    // Bus lines cross inverted so the cleared synchroniser reads as an idle high bus
    pmc_sync #(.W(24)) u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .din({~scl, ~sda_in, addr_lsb, usb_source_valid, ac_source_valid,
              undervolt_lockout, taper_comparator, taper_timer_done,
              charge_state_flags, rail_state_flags}),
        .dout(pins_s)
    );

    assign {scl_inv_s, sda_inv_s, addr_lsb_s, usb_ok, ac_ok, lockout, taper_cmp, taper_tmr,
            chg_flags, rail_flags} = pins_s;
    // Avoids a false clock and data edge right after reset
    assign scl_s = ~scl_inv_s;
    assign sda_s = ~sda_inv_s;

    // Serial port: edge and bus condition detection
    logic scl_d, sda_d;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
    assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

    // Register state
    logic [7:0] rail_mask, chg_ack, rail_ack, setup;
    logic [7:0] next_rail_mask, next_chg_ack, next_rail_ack, next_setup;

    function automatic logic [7:0] read_mux(input logic [7:0] ofs, input logic [7:0] cf,
                                            input logic [7:0] rf, input logic [7:0] cm,
                                            input logic [7:0] rm, input logic [7:0] ca,
                                            input logic [7:0] ra, input logic [7:0] st);
        logic [7:0] val;
        val = `PMC_UNMAPPED_DATA;
        if (ofs == `PMC_OFS_CHARGE_FLAGS) begin
            val = cf;
        end else if (ofs == `PMC_OFS_RAIL_FLAGS) begin
            val = rf;
        end else if (ofs == `PMC_OFS_CHARGE_MASK) begin
            val = cm;
        end else if (ofs == `PMC_OFS_RAIL_MASK) begin
            val = rm;
        end else if (ofs == `PMC_OFS_CHARGE_ACK) begin
            val = ca;
        end else if (ofs == `PMC_OFS_RAIL_ACK) begin
            val = ra;
        end else if (ofs == `PMC_OFS_CHARGER_SETUP) begin
            val = st;
        end
        return val;
    endfunction

    // Ack bits load on a status read and drop with their flag
    function automatic logic [7:0] ack_next(input logic [7:0] ack, input logic [7:0] flags,
                                            input logic load);
        logic [7:0] held;
        held = ack | (load ? flags : 8'h00);
        return held & flags;
    endfunction

    // Conditions still allowed to reach the interrupt pin
    function automatic logic [7:0] pending(input logic [7:0] flags, input logic [7:0] mask,
                                           input logic [7:0] ack);
        return flags & ~mask & ~ack;
    endfunction

    // Serial port state machine
    pmc_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [7:0] shift, next_shift, ptr, next_ptr;
    logic rw, next_rw, next_sda_oe_b;
    logic wr_stb, rd_stb;
    logic [7:0] rd_data;

    assign rd_data = read_mux(ptr, chg_flags, rail_flags, charge_event_mask,
                              rail_mask, chg_ack, rail_ack, setup);

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shift = shift;
        next_ptr = ptr;
        next_rw = rw;
        next_sda_oe_b = sda_oe_b;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        if (bus_start) begin
            next_state = PMC_ADDR;
            next_cnt = 4'h0;
            next_sda_oe_b = 1'b1;
        end else if (bus_stop) begin
            next_state = PMC_IDLE;
            next_sda_oe_b = 1'b1;
        end else begin
            case (state)
                PMC_ADDR, PMC_PTR, PMC_WDATA: begin
                    if (scl_rise) begin
                        next_shift = {shift[6:0], sda_s};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == `PMC_BITS_PER_BYTE) begin
                        next_cnt = 4'h0;
                        if (state == PMC_ADDR) begin
                            if (shift[7:1] == {`PMC_DEV_ADDR_MSBS, addr_lsb_s}) begin
                                next_rw = shift[0];
                                next_sda_oe_b = 1'b0;
                                next_state = PMC_ADDR_ACK;
                            end else begin
                                next_state = PMC_IDLE;
                            end
                        end else if (state == PMC_PTR) begin
                            next_ptr = shift;
                            next_sda_oe_b = 1'b0;
                            next_state = PMC_PTR_ACK;
                        end else begin
                            wr_stb = 1'b1;
                            next_sda_oe_b = 1'b0;
                            next_state = PMC_WDATA_ACK;
                        end
                    end
                end
                PMC_ADDR_ACK, PMC_RDATA_ACK: begin
                    if (state == PMC_RDATA_ACK && scl_rise && sda_s) begin
                        next_state = PMC_IDLE;
                    end else if (scl_fall && (state == PMC_RDATA_ACK || rw)) begin
                        // First byte loads as the ack clock falls
                        rd_stb = 1'b1;
                        next_shift = rd_data;
                        next_sda_oe_b = rd_data[7];
                        next_ptr = ptr + 8'h01;
                        next_cnt = 4'h0;
                        next_state = PMC_RDATA;
                    end else if (scl_fall) begin
                        next_sda_oe_b = 1'b1;
                        next_state = PMC_PTR;
                    end
                end
                PMC_PTR_ACK, PMC_WDATA_ACK: begin
                    if (scl_fall) begin
                        next_sda_oe_b = 1'b1;
                        if (state == PMC_WDATA_ACK) begin
                            next_ptr = ptr + 8'h01;
                        end
                        next_state = PMC_WDATA;
                    end
                end
                PMC_RDATA: begin
                    if (scl_fall) begin
                        if (cnt == `PMC_LAST_READ_BIT) begin
                            // Let go of the line for the master's answer
                            next_sda_oe_b = 1'b1;
                            next_state = PMC_RDATA_ACK;
                        end else begin
                            next_shift = {shift[6:0], 1'b0};
                            next_sda_oe_b = shift[6];
                            next_cnt = cnt + 4'h1;
                        end
                    end
                end
                default: begin
                    next_sda_oe_b = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= PMC_IDLE;
            cnt <= 4'h0;
            shift <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'b0;
            sda_oe_b <= 1'b1;
            sda_out <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            shift <= next_shift;
            ptr <= next_ptr;
            rw <= next_rw;
            sda_oe_b <= next_sda_oe_b;
            sda_out <= 1'b0;
        end
    end

    // Register updates and derived charger controls
    logic next_irq_b, next_force_on, next_restart, next_taper_flag;
    logic next_usb_500, next_usb_on, next_ac_on, src_present;

    always_comb begin
        next_rail_mask = rail_mask;
        next_setup = setup;
        next_restart = 1'b0;
        if (wr_stb && ptr == `PMC_OFS_RAIL_MASK) begin
            next_rail_mask = shift;
        end
        if (wr_stb && ptr == `PMC_OFS_CHARGER_SETUP) begin
            next_setup = shift;
            // Restart fires when the reset bit is taken back to zero
            next_restart = setup[`PMC_BIT_CHARGER_RESET] &
                           ~shift[`PMC_BIT_CHARGER_RESET];
        end
        // Writes to acknowledge registers are ignored
        next_chg_ack = ack_next(chg_ack, chg_flags,
                                rd_stb && ptr == `PMC_OFS_CHARGE_FLAGS);
        next_rail_ack = ack_next(rail_ack, rail_flags,
                                 rd_stb && ptr == `PMC_OFS_RAIL_FLAGS);
        next_irq_b = ~(|pending(chg_flags, charge_event_mask, chg_ack) |
                       |pending(rail_flags, rail_mask, rail_ack));
        src_present = usb_ok | ac_ok;
        next_force_on = ~setup[`PMC_BIT_AUTO_ON_INHIBIT] & src_present & ~lockout;
        next_taper_flag = setup[`PMC_BIT_TIMER_ENABLE] ? taper_tmr : taper_cmp;
        next_usb_500 = setup[`PMC_BIT_USB_500MA] & setup[`PMC_BIT_USB_ALLOWED];
        next_ac_on = setup[`PMC_BIT_CHARGE_ENABLE] & ac_ok;
        next_usb_on = setup[`PMC_BIT_CHARGE_ENABLE] & setup[`PMC_BIT_USB_ALLOWED] &
                      usb_ok & ~ac_ok;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rail_mask <= `PMC_RST_RAIL_MASK;
            chg_ack <= `PMC_RST_ACK;
            rail_ack <= `PMC_RST_ACK;
            setup <= `PMC_RST_CHARGER_SETUP;
            irq_b <= 1'b1;
            force_on <= 1'b0;
            standby_allowed <= 1'b1;
            charger_restart <= 1'b0;
            fast_timer_enable <= 1'b0;
            taper_flag <= 1'b0;
            charge_current_code <= 2'h3;
            usb_limit_500ma <= 1'b0;
            usb_charge_on <= 1'b0;
            ac_charge_on <= 1'b0;
        end else begin
            rail_mask <= next_rail_mask;
            chg_ack <= next_chg_ack;
            rail_ack <= next_rail_ack;
            setup <= next_setup;
            irq_b <= next_irq_b;
            force_on <= next_force_on;
            standby_allowed <= ~next_force_on;
            charger_restart <= next_restart;
            fast_timer_enable <= setup[`PMC_BIT_TIMER_ENABLE];
            taper_flag <= next_taper_flag;
            charge_current_code <= {setup[`PMC_BIT_CURRENT_MSB],
                                    setup[`PMC_BIT_CURRENT_LSB]};
            usb_limit_500ma <= next_usb_500;
            usb_charge_on <= next_usb_on;
            ac_charge_on <= next_ac_on;
        end
    end
endmodule
`default_nettype wire

//--- tb/pmc_host_model.sv
// Purpose: host on the two-wire port, master side
// Assumes: data line pulled up, host only releases or pulls low
// Notes: each clock phase lasts at least eight system clocks
`timescale 1ns/10ps
`default_nettype none
module pmc_host_model #(
    parameter logic [6:0] DEV = 7'h49
) (
    input wire logic clock,
    output logic scl,
    output logic sda_rel,
    input wire logic sda_line
);
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic half();
        repeat (8) @(negedge clock);
    endtask
    task automatic put_bit(input logic b);
        repeat (2) @(negedge clock);
        sda_rel = b;
        half();
        scl = 1'b1;
        half();
        scl = 1'b0;
    endtask
    task automatic get_bit(output logic b);
        repeat (2) @(negedge clock);
        sda_rel = 1'b1;
        half();
        scl = 1'b1;
        repeat (4) @(negedge clock);
        b = sda_line;
        repeat (4) @(negedge clock);
        scl = 1'b0;
    endtask
    task automatic start();
        repeat (2) @(negedge clock);
        sda_rel = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_rel = 1'b0;
        half();
        scl = 1'b0;
    endtask
    task automatic stop();
        repeat (2) @(negedge clock);
        sda_rel = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_rel = 1'b1;
        half();
    endtask
    task automatic send(input logic [7:0] d, inout logic nak);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(a);
        nak = nak | a;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic nak);
        nak = 1'b0;
        start();
        send({DEV, 1'b0}, nak);
        send(p, nak);
        send(d, nak);
        stop();
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic nak);
        nak = 1'b0;
        start();
        send({DEV, 1'b0}, nak);
        send(p, nak);
        start();
        send({DEV, 1'b1}, nak);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(1'b1);
        stop();
    endtask
endmodule
`default_nettype wire

//--- tb/pmc_charger_irq_regs_monitor.sv
// Purpose: port checks for the charger setup and interrupt bank
// Assumes: pin levels reach the outputs three clocks later
// Notes: bound to the top module
`timescale 1ns/10ps
`default_nettype none
module pmc_charger_irq_regs_monitor (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] charge_state_flags,
    input wire logic [7:0] rail_state_flags,
    input wire logic [7:0] charge_event_mask,
    input wire logic usb_source_valid,
    input wire logic ac_source_valid,
    input wire logic undervolt_lockout,
    input wire logic taper_comparator,
    input wire logic taper_timer_done,
    input wire logic irq_b,
    input wire logic force_on,
    input wire logic standby_allowed,
    input wire logic charger_restart,
    input wire logic fast_timer_enable,
    input wire logic taper_flag,
    input wire logic usb_charge_on,
    input wire logic ac_charge_on
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    wall_priority_a: assert property (ac_charge_on |-> !usb_charge_on)
        else $error("both sources charging");
    usb_source_a: assert property (usb_charge_on |->
        $past(usb_source_valid, 3) && !$past(ac_source_valid, 3)) else $error("usb charge bad");
    ac_source_a: assert property (ac_charge_on |-> $past(ac_source_valid, 3))
        else $error("ac charge without source");
    force_cause_a: assert property (force_on |->
        ($past(usb_source_valid, 3) || $past(ac_source_valid, 3)) && !$past(undervolt_lockout, 3))
        else $error("forced on without cause");
    standby_inverse_a: assert property (standby_allowed == !force_on)
        else $error("standby not inverse of forced on");
    restart_pulse_a: assert property ($rose(charger_restart) |=> !charger_restart)
        else $error("restart pulse too long");
    taper_select_a: assert property (taper_flag == (fast_timer_enable ?
        $past(taper_timer_done, 3) : $past(taper_comparator, 3))) else $error("taper source");
    irq_cause_a: assert property (!irq_b |-> ($past(rail_state_flags, 3) |
        ($past(charge_state_flags, 3) & ~$past(charge_event_mask, 1))) != 8'h00)
        else $error("interrupt without condition");
    cover property (!irq_b);
    cover property ($rose(charger_restart));
    cover property (force_on && usb_charge_on);
endmodule
bind pmc_charger_irq_regs pmc_charger_irq_regs_monitor u_pmc_charger_irq_regs_monitor (
    .clock, .rst_b, .charge_state_flags, .rail_state_flags, .charge_event_mask,
    .usb_source_valid, .ac_source_valid, .undervolt_lockout, .taper_comparator,
    .taper_timer_done, .irq_b, .force_on, .standby_allowed, .charger_restart,
    .fast_timer_enable, .taper_flag, .usb_charge_on, .ac_charge_on
);
`default_nettype wire

//--- tb/tb_pmc_charger_irq_regs.sv
// Purpose: self-checking bench for the charger setup and interrupt bank
// Assumes: host model drives the two-wire port, inputs change at falling edges
// Notes: reading a status register acknowledges its set bits
`timescale 1ns/10ps
`default_nettype none
module tb_pmc_charger_irq_regs;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic scl, sda_rel, sda_oe_b, irq_b, force_on, standby_allowed, charger_restart;
    logic fast_timer_enable, taper_flag, usb_limit_500ma, usb_charge_on, ac_charge_on;
    logic sda_out;
    logic [1:0] charge_current_code;
    logic [7:0] charge_state_flags = 8'h00;
    logic [7:0] rail_state_flags = 8'h00;
    logic [7:0] charge_event_mask = 8'hff;
    logic usb_source_valid = 1'b0;
    logic ac_source_valid = 1'b0;
    logic undervolt_lockout = 1'b0;
    logic taper_comparator = 1'b0;
    logic taper_timer_done = 1'b0;
    wire sda_line;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int pulses = 0;
    assign sda_line = sda_rel & (sda_oe_b | sda_out);
    always #12.5 clock = ~clock;
    pmc_host_model u_pmc_host_model (.clock, .scl, .sda_rel, .sda_line);
    pmc_charger_irq_regs u_pmc_charger_irq_regs (
        .clock, .rst_b, .scl, .sda_in(sda_line), .sda_out, .sda_oe_b, .addr_lsb(1'b1),
        .charge_state_flags, .rail_state_flags, .charge_event_mask, .usb_source_valid,
        .ac_source_valid, .undervolt_lockout, .taper_comparator, .taper_timer_done, .irq_b,
        .force_on, .standby_allowed, .charger_restart, .fast_timer_enable, .taper_flag,
        .charge_current_code, .usb_limit_500ma, .usb_charge_on, .ac_charge_on
    );
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(negedge clock) begin
        cycles++;
        if (charger_restart === 1'b1) pulses++;
        if (cycles == 60000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (6) @(negedge clock);
    endtask
    task automatic w(input logic [7:0] p, input logic [7:0] d);
        logic n;
        u_pmc_host_model.wr(p, d, n);
        chk({7'h0, n}, 8'h00);
    endtask
    task automatic rdc(input logic [7:0] p, input logic [7:0] e);
        logic n;
        logic [7:0] d;
        u_pmc_host_model.rd(p, d, n);
        chk({7'h0, n}, 8'h00);
        chk(d, e);
    endtask
    task automatic t_defaults();
        chk({6'h0, charge_current_code}, 8'h03);
        rdc(8'h04, 8'hff);
        rdc(8'h05, 8'h00);
        rdc(8'h06, 8'h00);
        rdc(8'h07, 8'h1b);
        rdc(8'h30, 8'hff);
    endtask
    task automatic t_current();
        for (int i = 0; i < 4; i++) begin
            w(8'h07, 8'h23 | 8'(i << 3));
            chk({6'h0, charge_current_code}, 8'(i));
        end
        w(8'h07, 8'h1f);
        chk({7'h0, usb_limit_500ma}, 8'h01);
        w(8'h07, 8'h1d);
        chk({7'h0, usb_limit_500ma}, 8'h00);
    endtask
    task automatic t_sources();
        w(8'h07, 8'h1b);
        usb_source_valid = 1'b1;
        settle();
        chk({6'h0, force_on, standby_allowed}, 8'h02);
        chk({6'h0, usb_charge_on, ac_charge_on}, 8'h02);
        ac_source_valid = 1'b1;
        settle();
        chk({6'h0, usb_charge_on, ac_charge_on}, 8'h01);
        undervolt_lockout = 1'b1;
        settle();
        chk({6'h0, force_on, standby_allowed}, 8'h01);
        undervolt_lockout = 1'b0;
        w(8'h07, 8'h9b);
        chk({6'h0, force_on, standby_allowed}, 8'h01);
        w(8'h07, 8'h1a);
        chk({6'h0, usb_charge_on, ac_charge_on}, 8'h00);
        ac_source_valid = 1'b0;
        w(8'h07, 8'h19);
        chk({6'h0, usb_charge_on, ac_charge_on}, 8'h00);
        usb_source_valid = 1'b0;
    endtask
    task automatic t_restart();
        int p;
        p = pulses;
        w(8'h07, 8'h7b);
        chk(8'(pulses - p), 8'h00);
        w(8'h07, 8'h3b);
        chk(8'(pulses - p), 8'h01);
        chk({7'h0, fast_timer_enable}, 8'h01);
        taper_timer_done = 1'b1;
        settle();
        chk({7'h0, taper_flag}, 8'h01);
        w(8'h07, 8'h1b);
        chk({7'h0, taper_flag}, 8'h00);
        chk({7'h0, fast_timer_enable}, 8'h00);
        taper_comparator = 1'b1;
        settle();
        chk({7'h0, taper_flag}, 8'h01);
    endtask
    task automatic t_irq();
        rail_state_flags = 8'h05;
        settle();
        chk({7'h0, irq_b}, 8'h01);
        w(8'h04, 8'hfb);
        chk({7'h0, irq_b}, 8'h00);
        charge_event_mask = 8'hfc;
        charge_state_flags = 8'h03;
        settle();
        rdc(8'h01, 8'h03);
        chk({7'h0, irq_b}, 8'h00);
        rdc(8'h02, 8'h05);
        chk({7'h0, irq_b}, 8'h01);
        rdc(8'h05, 8'h03);
        charge_state_flags = 8'h01;
        rail_state_flags = 8'h01;
        settle();
        rdc(8'h05, 8'h01);
        rdc(8'h06, 8'h01);
        w(8'h05, 8'hff);
        rdc(8'h05, 8'h01);
    endtask
    initial begin
        repeat (12) @(negedge clock);
        rst_b = 1'b1;
        settle();
        chk({7'h0, irq_b}, 8'h01);
        chk({7'h0, sda_out}, 8'h00);
        t_defaults();
        t_current();
        t_sources();
        t_restart();
        t_irq();
        tally_and_finish();
    end
endmodule
`default_nettype wire
